/* sfpc_pkg.sv */
package sfpc_pkg;
    localparam int SFPC_OP_BITS = 8;
    localparam int SFPC_FIFO_W = 8;
    localparam int SFPC_FIFO_D = 8;
    localparam logic [2:0] SFPC_BIT_LAST = 3'h7;
    localparam logic [2:0] SFPC_BIT_RST = 3'h0;
    localparam logic [7:0] SFPC_BYTE_RST = 8'h00;
    // opcode classes the pin logic must tell apart
    localparam logic [7:0] SFPC_OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] SFPC_OP_BUF_PROG = 8'h83;
    localparam logic [7:0] SFPC_OP_PAGE_ERASE = 8'h81;
    localparam logic [7:0] SFPC_OP_BLOCK_ERASE = 8'h50;
    localparam logic [7:0] SFPC_OP_SECT_ERASE = 8'h7c;
    localparam logic [7:0] SFPC_OP_PROT_CMD = 8'h3d;
    // second to fourth bytes of the four-byte protection commands
    localparam logic [7:0] SFPC_PROT_B1 = 8'h2a;
    localparam logic [7:0] SFPC_PROT_B2 = 8'h7f;
    localparam logic [7:0] SFPC_PROT_ENABLE = 8'ha9;
    localparam logic [7:0] SFPC_PROT_ERASE_REG = 8'hcf;
    localparam logic [7:0] SFPC_PROT_PROG_REG = 8'hfc;
    localparam logic [7:0] SFPC_PROT_LOCKDOWN = 8'h30;
    // self-timed busy time for program / erase, protection writes and lockdown, in ns and in system clocks
    localparam int SFPC_BUSY_NS = 2000;
    localparam int SFPC_CLK_NS = 5;
    localparam int SFPC_BUSY_CYC = SFPC_BUSY_NS / SFPC_CLK_NS;
    localparam logic [11:0] SFPC_BUSY_CNT = 12'(SFPC_BUSY_CYC);
    localparam logic [11:0] SFPC_CNT_RST = 12'h000;
    typedef enum logic [2:0] {
        SFPC_IDLE,
        SFPC_OPCODE,
        SFPC_PROT,
        SFPC_ACTIVE,
        SFPC_DISCARD,
        SFPC_BUSY
    } sfpc_state_t;
endpackage

/* sfpc_sync.sv */
`timescale 1ns/1ps
module sfpc_sync
    import sfpc_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // levels
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sfpc_sync_t;
    sfpc_sync_t st;
    sfpc_sync_t next_st;

    always_comb begin
        next_st = st;
        next_st.meta = i_async;
        next_st.stable = st.meta;
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            st <= {INIT, INIT};
        end else begin
            st <= next_st;
        end
    end

    assign o_sync = st.stable;
endmodule // sfpc_sync

/* sfpc_fifo.sv */
`timescale 1ns/1ps
module sfpc_fifo
    import sfpc_pkg::*;
#(
    parameter int WIDTH = SFPC_FIFO_W,
    parameter int DEPTH = SFPC_FIFO_D
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_flush,
    // fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } sfpc_fifo_t;
    sfpc_fifo_t st;
    sfpc_fifo_t next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign o_in_ready = (st.cnt != (AW+1)'(DEPTH));
    assign o_out_valid = (st.cnt != '0);
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem[st.rp];

    always_comb begin
        next_st = st;
        if (push) next_st.wp = st.wp + 1'b1;
        if (pop) next_st.rp = st.rp + 1'b1;
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (i_flush) next_st = '0;
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (push) mem[st.wp] <= i_in_data;
    end
endmodule // sfpc_fifo

/* sfpc_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - serial input is captured on each rising serial clock edge
// - opcode, address and write data all arrive on serial input
// - serial input is ignored while chip select is high
// - serial output changes only on falling serial clock edges
// - serial output is high impedance while chip select is high
// - write-protect low blocks every program and erase command, whatever the sector
// - write-protect low blocks any protection register change
// - program or erase under write-protect is discarded, nothing done
// - discarded command returns to idle when chip select rises
// - enable-protection and lockdown still run under write-protect
// - unconnected write-protect reads as deasserted via pull-up
// - reset low aborts work and forces the state machine idle
// - held in reset while reset is low, resumes once high
// - internal power-on reset gives a defined state
// - chip select rise during busy waits for operation end
// - msb first, 8-bit opcode leads every instruction
module sfpc_top
    import sfpc_pkg::*;
(
    // clock and power-on reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // serial pins
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_si,
    output logic o_so,
    output logic o_so_oe,
    // control pins; i_wp_n floats high through the pad pull-up
    input wire logic i_wp_n,
    input wire logic i_reset_n,
    // received bytes toward the command core
    output logic o_rx_valid,
    input wire logic i_rx_ready,
    output logic [7:0] o_rx_data,
    // read data from the command core
    input wire logic i_tx_valid,
    output logic i_tx_ready_unused,
    input wire logic [7:0] i_tx_data,
    // status and command outcome
    output logic o_busy,
    output logic o_prog_erase_go,
    output logic o_prot_write_go,
    output logic o_prot_enable_go,
    output logic o_lockdown_go,
    output logic o_cmd_discard,
    output logic o_wp_active,
    output logic o_overflow
);
    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [4:0] pins_s;
    logic cs_n_s;
    logic sck_s;
    logic si_s;
    logic wp_n_s;
    logic rst_n_s;

    sfpc_sync #(
        .WIDTH(5),
        // sck idles low so no false edge follows reset
        .INIT(5'h13)
    ) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_async({i_cs_n, i_sck, i_si, i_wp_n, i_reset_n}),
        .o_sync(pins_s)
    );

    assign cs_n_s = pins_s[4];
    assign sck_s = pins_s[3];
    assign si_s = pins_s[2];
    assign wp_n_s = pins_s[1];
    assign rst_n_s = pins_s[0];

    ////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        sfpc_state_t fsm;
        logic sck_d;
        logic [2:0] bitn;
        logic [7:0] sh;
        logic [7:0] op;
        logic [1:0] prot_idx;
        logic prot_ok;
        logic wp_latched;
        logic [7:0] rx_data;
        logic rx_push;
        logic [7:0] tx_sh;
        logic [2:0] tx_bit;
        logic so;
        logic so_oe;
        logic [11:0] busy_cnt;
        logic pe_go;
        logic pw_go;
        logic pen_go;
        logic lock_go;
        logic discard;
        logic ovf;
    } sfpc_top_t;
    sfpc_top_t st;
    sfpc_top_t next_st;

    logic sck_rise;
    logic sck_fall;
    logic [7:0] byte_in;
    logic byte_done;
    logic is_prog_erase;
    logic fifo_in_ready;
    logic tx_pop;

    assign sck_rise = sck_s && !st.sck_d;
    assign sck_fall = !sck_s && st.sck_d;
    assign byte_in = {st.sh[6:0], si_s};
    assign byte_done = sck_rise && !cs_n_s && (st.bitn == SFPC_BIT_LAST);
    assign is_prog_erase = (byte_in == SFPC_OP_PAGE_PROG)
        || (byte_in == SFPC_OP_BUF_PROG)
        || (byte_in == SFPC_OP_PAGE_ERASE)
        || (byte_in == SFPC_OP_BLOCK_ERASE)
        || (byte_in == SFPC_OP_SECT_ERASE);
    // a fresh byte is loaded only at the frame's byte boundary
    assign tx_pop = sck_fall && !cs_n_s && (st.tx_bit == SFPC_BIT_RST)
        && i_tx_valid;
    assign i_tx_ready_unused = tx_pop;

    always_comb begin
        next_st = st;
        next_st.sck_d = sck_s;
        next_st.rx_push = 1'b0;
        next_st.pe_go = 1'b0;
        next_st.pw_go = 1'b0;
        next_st.pen_go = 1'b0;
        next_st.lock_go = 1'b0;
        next_st.discard = 1'b0;
        // wp level frozen once chip select falls and idle is left, so a whole command sees one value
        if (st.fsm == SFPC_IDLE) next_st.wp_latched = !wp_n_s;
        if (cs_n_s) begin
            next_st.bitn = SFPC_BIT_RST;
            next_st.tx_bit = SFPC_BIT_RST;
            next_st.so_oe = 1'b0;
        end else if (sck_rise) begin
            next_st.sh = byte_in;
            next_st.bitn = st.bitn + 3'h1;
        end
        if (tx_pop) begin
            next_st.so = i_tx_data[7];
            next_st.tx_sh = {i_tx_data[6:0], 1'b0};
            next_st.tx_bit = 3'h1;
            next_st.so_oe = 1'b1;
        end else if (sck_fall && !cs_n_s && st.tx_bit != SFPC_BIT_RST) begin
            next_st.so = st.tx_sh[7];
            next_st.tx_sh = {st.tx_sh[6:0], 1'b0};
            next_st.tx_bit = st.tx_bit + 3'h1;
        end
        if (byte_done && st.fsm != SFPC_DISCARD && st.fsm != SFPC_BUSY)
        begin
            next_st.rx_data = byte_in;
            next_st.rx_push = 1'b1;
            if (!fifo_in_ready) next_st.ovf = 1'b1;
        end
        case (st.fsm)
            SFPC_IDLE: begin
                if (!cs_n_s) next_st.fsm = SFPC_OPCODE;
            end
            SFPC_OPCODE: begin
                if (cs_n_s) begin
                    next_st.fsm = SFPC_IDLE;
                end else if (byte_done) begin
                    next_st.op = byte_in;
                    if (is_prog_erase && st.wp_latched) begin
                        next_st.fsm = SFPC_DISCARD;
                        next_st.discard = 1'b1;
                    end else if (byte_in == SFPC_OP_PROT_CMD) begin
                        next_st.fsm = SFPC_PROT;
                        next_st.prot_idx = 2'h1;
                        next_st.prot_ok = 1'b1;
                    end else begin
                        next_st.fsm = SFPC_ACTIVE;
                    end
                end
            end
            SFPC_PROT: begin
                if (byte_done) begin
                    next_st.prot_idx = st.prot_idx + 2'h1;
                    if (st.prot_idx == 2'h1 && byte_in != SFPC_PROT_B1)
                        next_st.prot_ok = 1'b0;
                    if (st.prot_idx == 2'h2 && byte_in != SFPC_PROT_B2)
                        next_st.prot_ok = 1'b0;
                    if (st.prot_idx == 2'h3) next_st.sh = byte_in;
                end
                if (cs_n_s) begin
                    next_st.fsm = SFPC_IDLE;
                    if (st.prot_ok && st.prot_idx == 2'h0) begin
                        if (st.sh == SFPC_PROT_ENABLE) begin
                            next_st.pen_go = 1'b1;
                        end else if (st.sh == SFPC_PROT_LOCKDOWN) begin
                            next_st.lock_go = 1'b1;
                            next_st.fsm = SFPC_BUSY;
                            next_st.busy_cnt = SFPC_BUSY_CNT;
                        end else if (st.sh == SFPC_PROT_ERASE_REG
                                || st.sh == SFPC_PROT_PROG_REG) begin
                            if (st.wp_latched) begin
                                next_st.discard = 1'b1;
                            end else begin
                                next_st.pw_go = 1'b1;
                                next_st.fsm = SFPC_BUSY;
                                next_st.busy_cnt = SFPC_BUSY_CNT;
                            end
                        end
                    end
                end
            end
            SFPC_ACTIVE: begin
                if (cs_n_s) begin
                    if (st.op == SFPC_OP_PAGE_PROG || st.op == SFPC_OP_BUF_PROG
                            || st.op == SFPC_OP_PAGE_ERASE
                            || st.op == SFPC_OP_BLOCK_ERASE
                            || st.op == SFPC_OP_SECT_ERASE) begin
                        next_st.pe_go = 1'b1;
                        next_st.fsm = SFPC_BUSY;
                        next_st.busy_cnt = SFPC_BUSY_CNT;
                    end else begin
                        next_st.fsm = SFPC_IDLE;
                    end
                end
            end
            SFPC_DISCARD: begin
                if (cs_n_s) next_st.fsm = SFPC_IDLE;
            end
            SFPC_BUSY: begin
                // standby only once the self-timed work ends
                if (st.busy_cnt == SFPC_CNT_RST) begin
                    if (cs_n_s) next_st.fsm = SFPC_IDLE;
                end else begin
                    next_st.busy_cnt = st.busy_cnt - 12'h001;
                end
            end
            default: next_st.fsm = SFPC_IDLE;
        endcase
        if (!rst_n_s) begin
            next_st = '0;
            next_st.fsm = SFPC_IDLE;
            next_st.sck_d = sck_s;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // received byte buffer; core stalls it via i_rx_ready
    sfpc_fifo #(
        .WIDTH(SFPC_FIFO_W),
        .DEPTH(SFPC_FIFO_D)
    ) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_flush(!rst_n_s),
        .i_in_valid(st.rx_push),
        .o_in_ready(fifo_in_ready),
        .i_in_data(st.rx_data),
        .o_out_valid(o_rx_valid),
        .i_out_ready(i_rx_ready),
        .o_out_data(o_rx_data)
    );

    assign o_so = st.so;
    assign o_so_oe = st.so_oe && !cs_n_s;
    assign o_busy = (st.fsm == SFPC_BUSY);
    assign o_prog_erase_go = st.pe_go;
    assign o_prot_write_go = st.pw_go;
    assign o_prot_enable_go = st.pen_go;
    assign o_lockdown_go = st.lock_go;
    assign o_cmd_discard = st.discard;
    assign o_wp_active = st.wp_latched;
    assign o_overflow = st.ovf;

    ////////////////////////////////////////////////////////////////////
    // checks
    a_si_ignored_cs: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        cs_n_s |=> !st.rx_push) else $error("byte taken while deselected");
    a_so_hiz_cs: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        cs_n_s |-> !o_so_oe) else $error("so driven while deselected");
    a_so_fall_only: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        $changed(st.so) |-> ($past(sck_fall) || $past(!rst_n_s)))
        else $error("so moved off fall");
    a_wp_discard: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        st.wp_latched |-> !next_st.pe_go) else $error("prog under wp");
    a_prot_reg_wp: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        st.pw_go |-> !$past(st.wp_latched)) else $error("prot write under wp");
    a_discard_idle: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (st.fsm == SFPC_DISCARD && cs_n_s && rst_n_s) |=> st.fsm == SFPC_IDLE)
        else $error("discard did not idle");
    a_reset_idle: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        !rst_n_s |=> (st.fsm == SFPC_IDLE && !st.so_oe)) else $error("no reset");
    a_busy_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (o_busy && st.busy_cnt != SFPC_CNT_RST && rst_n_s) |=> o_busy)
        else $error("left busy early");
endmodule // sfpc_top

/* sfpc_host.sv */
`timescale 1ns/1ps
module sfpc_host (
    // pacing clock
    input wire logic i_clk_sys,
    // serial pins seen from the host
    input wire logic i_so,
    output logic o_cs_n,
    output logic o_sck,
    output logic o_si
);
    // high phase (a third) of the 120 ns link period, in system clocks
    localparam int HALF = 8;
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    // whole bytes, msb first, one chip select frame
    task automatic frame(input logic [7:0] b [12], input int n,
                         output logic [7:0] rd);
        rd = 8'h00;
        o_cs_n <= 1'b0;
        for (int i = 0; i < n * 8; i++) begin
            o_si <= b[i / 8][7 - i % 8];
            tick(HALF);
            o_sck <= 1'b1;
            tick(HALF);
            o_sck <= 1'b0;
            // sample seven clocks into the sixteen-clock low phase, output has long settled
            tick(HALF - 1);
            if (i / 8 == 1) begin
                rd[15 - i] = i_so;
            end
            tick(1);
        end
        o_cs_n <= 1'b1;
        // released line shows the last bit inverted, not the last bit
        o_si <= ~o_si;
        tick(HALF);
    endtask
    // clock and data wiggle while deselected
    task automatic noise();
        for (int i = 0; i < 16; i++) begin
            o_si <= i[0];
            o_sck <= ~o_sck;
            tick(HALF);
        end
        o_sck <= 1'b0;
    endtask
endmodule // sfpc_host

/* serial_flash_pin_control_test.sv */
`timescale 1ns/1ps
module serial_flash_pin_control_test;
    import sfpc_pkg::*;
    typedef struct packed {
        logic [31:0] cmd;
        logic wp;
        logic [4:0] exp;
    } sfpc_row_t;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic reset_n = 1'b1;
    logic wp_n = 1'b1;
    logic rx_ready = 1'b1;
    logic cs_n, sck, si, so, so_oe, rx_valid, tx_ready, busy;
    logic pe_go, pw_go, en_go, ld_go, discard, wp_active, overflow;
    logic [7:0] rx_data;
    logic [4:0] seen = 5'h00;
    logic clr = 1'b0;
    logic [7:0] rxq [$];
    int busy_len = 0;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    // outcome bits: prog/erase, prot write, enable, lockdown, discard
    sfpc_row_t rows [13] = '{
        '{32'h02000000, 1'b1, 5'h10}, '{32'h02000000, 1'b0, 5'h01},
        '{32'h83000000, 1'b0, 5'h01}, '{32'h81000000, 1'b0, 5'h01},
        '{32'h50000000, 1'b0, 5'h01}, '{32'h7c000000, 1'b0, 5'h01},
        '{32'h7c000000, 1'b1, 5'h10}, '{32'h3d2a7ffc, 1'b1, 5'h08},
        '{32'h3d2a7ffc, 1'b0, 5'h01}, '{32'h3d2a7fcf, 1'b0, 5'h01},
        '{32'h3d2a7fcf, 1'b1, 5'h08}, '{32'h3d2a7fa9, 1'b0, 5'h04},
        '{32'h3d2a7f30, 1'b0, 5'h02}};
    always #2.5 clk = ~clk;
    sfpc_host u_host (.i_clk_sys(clk), .i_so(so), .o_cs_n(cs_n),
        .o_sck(sck), .o_si(si));
    sfpc_top DUT (.i_clk_sys(clk), .i_rstn(rstn), .i_cs_n(cs_n),
        .i_sck(sck), .i_si(si), .o_so(so), .o_so_oe(so_oe),
        .i_wp_n(wp_n), .i_reset_n(reset_n), .o_rx_valid(rx_valid),
        .i_rx_ready(rx_ready), .o_rx_data(rx_data), .i_tx_valid(1'b1),
        .i_tx_ready_unused(tx_ready), .i_tx_data(8'ha5), .o_busy(busy),
        .o_prog_erase_go(pe_go), .o_prot_write_go(pw_go),
        .o_prot_enable_go(en_go), .o_lockdown_go(ld_go),
        .o_cmd_discard(discard), .o_wp_active(wp_active),
        .o_overflow(overflow));
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (clr) begin
            seen <= 5'h00;
            busy_len <= 0;
            rxq.delete();
        end else begin
            seen <= seen | {pe_go, pw_go, en_go, ld_go, discard};
            if (busy === 1'b1) begin
                busy_len <= busy_len + 1;
            end
            if (rx_valid === 1'b1 && rx_ready) begin
                rxq.push_back(rx_data);
            end
        end
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string msg);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic clear_seen();
        clr <= 1'b1;
        tick(1);
        clr <= 1'b0;
        tick(1);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 1000 && busy !== 1'b0; i++) begin
            tick(1);
        end
        check(32'(busy), 32'h0, "busy never ended");
    endtask
    task automatic run_row(input sfpc_row_t r);
        logic [7:0] b [12];
        logic [7:0] rd;
        for (int i = 0; i < 12; i++) begin
            b[i] = (i < 4) ? r.cmd[31 - 8 * i -: 8] : 8'h00;
        end
        wp_n <= r.wp;
        clear_seen();
        tick(6);
        u_host.frame(b, 4, rd);
        tick(20);
        check(32'(seen), 32'(r.exp), "command outcome");
        if (r.wp) begin
            check(32'(rxq[0]), 32'(r.cmd[31:24]), "opcode byte");
        end
        wait_idle();
        if (r.exp[4]) begin
            check(32'(busy_len >= SFPC_BUSY_CYC - 2 &&
                busy_len <= SFPC_BUSY_CYC + 2), 32'h1, "busy length");
        end
    endtask
    task automatic report_and_stop();
        if (n_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] b [12];
        logic [7:0] rd;
        tick(6);
        rstn <= 1'b1;
        tick(2);
        check(32'({so_oe, busy, overflow}), 32'h0, "power-on state");
        tick(6);
        foreach (rows[k]) begin
            run_row(rows[k]);
        end
        // deselected traffic must leave no trace
        wp_n <= 1'b1;
        clear_seen();
        u_host.noise();
        tick(20);
        check(32'(rxq.size()), 32'h0, "bytes while deselected");
        check(32'(so_oe), 32'h0, "output driven while deselected");
        // pin reset held across a whole program frame
        clear_seen();
        reset_n <= 1'b0;
        tick(4);
        u_host.frame('{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 4, rd);
        tick(20);
        check(32'({seen, busy}), 32'h0, "activity during pin reset");
        reset_n <= 1'b1;
        tick(8);
        // pin reset aborts a running program
        run_row(rows[11]);
        wp_n <= 1'b1;
        u_host.frame('{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 4, rd);
        tick(20);
        check(32'(busy), 32'h1, "program started");
        reset_n <= 1'b0;
        tick(6);
        check(32'(busy), 32'h0, "reset did not abort");
        reset_n <= 1'b1;
        tick(8);
        run_row(rows[12]);
        // stalled drain side: fill past the buffer, then empty it
        rx_ready <= 1'b0;
        clear_seen();
        for (int i = 0; i < 12; i++) begin
            b[i] = (i == 0) ? 8'h0b : 8'(i);
        end
        u_host.frame(b, 10, rd);
        tick(20);
        check(32'(rd), 32'h000000a5, "read byte on output");
        check(32'(so_oe), 32'h0, "output left driven");
        check(32'({overflow, rx_valid}), 32'h3, "full buffer state");
        rx_ready <= 1'b1;
        tick(20);
        check(32'(rxq.size()), 32'h8, "drained byte count");
        check(32'(rxq[0]), 32'h0000000b, "first drained byte");
        check(32'(rxq[7]), 32'h00000007, "last drained byte");
        report_and_stop();
    end
endmodule // serial_flash_pin_control_test
